// ===== src/lechs_pkg.sv
// package for the lane error counter hold and status bank
// assumes a byte wide register port driven by the serial configuration front end
// How it works
// RULE1: hold enabled counter stops at 0xFF
// RULE2: hold clear counter wraps back to zero
// RULE3: bit2 control char, bit1 table, bit0 disparity
// RULE4: software changes hold only during lane reset; the bank takes hold writes at any time, with no soft reset interlock
// RULE5: hold field resets 0x7, upper bits zero
// RULE6: reached bit sets at terminal count
// RULE7: status bit3 shows lane enabled, resets zero
// RULE8: counter reset also clears its reached bit
package lechs_pkg;

    // register port geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 8;

    // register offsets
    localparam logic [11:0] LANE6_ERROR_HOLD_ENABLE_ADDR = 12'h48E;
    localparam logic [11:0] LANE7_ERROR_HOLD_ENABLE_ADDR = 12'h48F;
    localparam logic [11:0] LANE0_ERROR_STATUS_ADDR      = 12'h490;
    localparam logic [11:0] LANE1_ERROR_STATUS_ADDR      = 12'h491;

    // field positions
    localparam int HOLD_FIELD_MSB  = 2;
    localparam int REACHED_MSB     = 2;
    localparam int ACTIVE_FLAG_BIT = 3;
    localparam int CTRL_CHAR_BIT   = 2;
    localparam int TABLE_BIT       = 1;
    localparam int DISPARITY_BIT   = 0;

    // reset values and terminal count
    localparam logic [2:0] HOLD_RESET       = 3'h7;
    localparam logic [2:0] REACHED_RESET    = 3'h0;
    localparam logic [7:0] TERMINAL_COUNT   = 8'hFF;
    localparam logic [7:0] READ_IDLE_VALUE  = 8'h00;
    localparam logic [3:0] ACTIVE_RESET     = 4'h0;

    // one error event per counter of a lane, bit order as in the fields
    typedef struct packed {
        logic unexpected_control_char_error;
        logic not_in_table_error;
        logic bad_disparity_error;
    } lechs_err_t;

    // register port request
    typedef struct packed {
        logic [11:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
    } lechs_req_t;

endpackage

// ===== src/lechs_lane_cnt.sv
// three error counters of one lane with hold or wrap and reached flags
// assumes error pulses and counter clear on the register clock
`timescale 1ns/1ps
`default_nettype none
module lechs_lane_cnt
(
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire logic [2:0]            hold_en,
    input  wire lechs_pkg::lechs_err_t err,
    input  wire logic                  cnt_clr,
    output logic      [2:0][7:0]       count,
    output logic      [2:0]            reached
);
    import lechs_pkg::*;

    logic [2:0] err_bits;

    assign err_bits = err; // RULE3

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_cnt
            logic [7:0] cnt_ff;
            logic [7:0] nxt_cnt;
            logic       reach_ff;
            logic       nxt_reach;
            logic       at_term;

            // saturate only when hold is on, otherwise plain 8 bit wrap
            assign at_term = (cnt_ff == TERMINAL_COUNT);
            assign nxt_cnt = cnt_clr ? {7'h00, err_bits[g]}
                           : !err_bits[g] ? cnt_ff
                           : (at_term && hold_en[g]) ? cnt_ff // RULE1
                           : cnt_ff + 8'h01; // RULE2
            // sticky until the counter is cleared; a clear returns well below 0xFF
            assign nxt_reach = (nxt_cnt == TERMINAL_COUNT) // RULE6
                             | (reach_ff & ~cnt_clr); // RULE8

            // counter and flag registers
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    cnt_ff   <= 8'h00;
                    reach_ff <= 1'b0;
                end
                else
                begin
                    cnt_ff   <= nxt_cnt;
                    reach_ff <= nxt_reach;
                end
            end

            assign count[g]   = cnt_ff;
            assign reached[g] = reach_ff;
        end
    endgenerate

endmodule
`default_nettype wire

// ===== src/lechs_top.sv
// lane error counter hold enable and status register bank
// assumes the serial configuration front end issues single cycle rd or wr strobes
// assumes lane soft reset levels and error pulses arrive on REF_CLK
`timescale 1ns/1ps
`default_nettype none
module lechs_top
(
    input  wire logic                     REF_CLK,
    input  wire logic                     NRST,
    // register port from the configuration serial port
    input  wire lechs_pkg::lechs_req_t    REG_REQ,
    output logic      [7:0]               REG_RDATA,
    output logic                          REG_RVALID,
    // lane 0 and 1 hold enables live in neighbouring registers
    input  wire logic [2:0]               LANE0_HOLD_EN,
    input  wire logic [2:0]               LANE1_HOLD_EN,
    // lane deserializer soft reset levels, high while held in reset
    input  wire logic [3:0]               LANE_SOFT_RESET,
    // error events, index 0 lane0, 1 lane1, 2 lane6, 3 lane7
    input  wire lechs_pkg::lechs_err_t [3:0] LANE_ERR,
    // per lane counter clear by user
    input  wire logic [3:0]               LANE_CNT_CLR,
    // counter values for the counter readback registers
    output logic      [3:0][2:0][7:0]     LANE_COUNT,
    // hold fields for lanes 6 and 7
    output logic      [2:0]               LANE6_HOLD_EN,
    output logic      [2:0]               LANE7_HOLD_EN,
    // reached flags for lanes 6 and 7, their status registers sit elsewhere
    output logic      [2:0]               LANE6_REACHED,
    output logic      [2:0]               LANE7_REACHED
);
    import lechs_pkg::*;

    // hold enable registers
    logic [2:0] lane6_hold_enable_field_ff;
    logic [2:0] nxt_lane6_hold;
    logic [2:0] lane7_hold_enable_field_ff;
    logic [2:0] nxt_lane7_hold;

    // read path registers
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic       rvalid_ff;

    // address decode
    logic       hit_hold6;
    logic       hit_hold7;
    logic       hit_stat0;
    logic       hit_stat1;

    // per lane wiring
    logic [3:0][2:0] lane_hold;
    logic [3:0][2:0] lane_reached;
    logic [3:0]      lane_active_ff;
    logic [3:0]      nxt_lane_active;
    logic [7:0]      lane0_status_reg;
    logic [7:0]      lane1_status_reg;

    // address decode as named wires
    assign hit_hold6 = (REG_REQ.addr == LANE6_ERROR_HOLD_ENABLE_ADDR);
    assign hit_hold7 = (REG_REQ.addr == LANE7_ERROR_HOLD_ENABLE_ADDR);
    assign hit_stat0 = (REG_REQ.addr == LANE0_ERROR_STATUS_ADDR);
    assign hit_stat1 = (REG_REQ.addr == LANE1_ERROR_STATUS_ADDR);

    // only the low field is stored, reserved bits have no flops
    // no interlock with lane soft reset: a live change is software's fault
    assign nxt_lane6_hold = (REG_REQ.wr && hit_hold6) ?
                            REG_REQ.wdata[HOLD_FIELD_MSB:0] : lane6_hold_enable_field_ff;
    assign nxt_lane7_hold = (REG_REQ.wr && hit_hold7) ?
                            REG_REQ.wdata[HOLD_FIELD_MSB:0] : lane7_hold_enable_field_ff;

    // hold fields come up all ones so every lane 6 and 7 counter saturates
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            lane6_hold_enable_field_ff <= HOLD_RESET; // RULE5
            lane7_hold_enable_field_ff <= HOLD_RESET; // RULE5
        end
        else
        begin
            lane6_hold_enable_field_ff <= nxt_lane6_hold;
            lane7_hold_enable_field_ff <= nxt_lane7_hold;
        end
    end

    // lane order inside the vectors: 0, 1, 6, 7
    assign lane_hold[0] = LANE0_HOLD_EN;
    assign lane_hold[1] = LANE1_HOLD_EN;
    assign lane_hold[2] = lane6_hold_enable_field_ff;
    assign lane_hold[3] = lane7_hold_enable_field_ff;

    // counters of every lane handled here, hold or wrap per counter
    genvar l;
    generate
        for (l = 0; l < 4; l++)
        begin : g_lane
            lechs_lane_cnt lechs_lane_cnt_inst
            (
                .clk     (REF_CLK),
                .nrst    (NRST),
                .hold_en (lane_hold[l]),
                .err     (LANE_ERR[l]),
                .cnt_clr (LANE_CNT_CLR[l]),
                .count   (LANE_COUNT[l]),
                .reached (lane_reached[l])
            );
        end
    endgenerate

    // lane active flag registered so the status bit reads zero out of reset
    // costs one cycle of lag behind the soft reset level, harmless for software
    assign nxt_lane_active = ~LANE_SOFT_RESET; // RULE7

    // lane active flags
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            lane_active_ff <= ACTIVE_RESET; // RULE7
        end
        else
        begin
            lane_active_ff <= nxt_lane_active;
        end
    end

    // status bytes: bit 3 active, bits 2:0 reached, upper bits read zero
    assign lane0_status_reg = {4'h0, lane_active_ff[0], lane_reached[0]}; // RULE7
    assign lane1_status_reg = {4'h0, lane_active_ff[1], lane_reached[1]}; // RULE7

    // read mux, unmapped offsets answer zero
    assign nxt_rdata = !REG_REQ.rd ? rdata_ff
                     : hit_hold6   ? {5'h00, lane6_hold_enable_field_ff} // RULE5
                     : hit_hold7   ? {5'h00, lane7_hold_enable_field_ff} // RULE5
                     : hit_stat0   ? lane0_status_reg // RULE6
                     : hit_stat1   ? lane1_status_reg // RULE6
                     : READ_IDLE_VALUE;

    // read data held until the next read so a slow shifter can pick it up
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            rdata_ff  <= READ_IDLE_VALUE;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= REG_REQ.rd;
        end
    end

    // outputs
    assign REG_RDATA     = rdata_ff;
    assign REG_RVALID    = rvalid_ff;
    assign LANE6_HOLD_EN = lane6_hold_enable_field_ff;
    assign LANE7_HOLD_EN = lane7_hold_enable_field_ff;
    assign LANE6_REACHED = lane_reached[2];
    assign LANE7_REACHED = lane_reached[3];

endmodule
`default_nettype wire

// ===== testbench/lechs_host.sv
// host model of the configuration serial port
// assumes single cycle rd or wr strobes launched just after the clock edge
`timescale 1ns/1ps
`default_nettype none
module lechs_host
(
    input  wire logic                  REF_CLK,
    output var  lechs_pkg::lechs_req_t REG_REQ
);
    import lechs_pkg::*;

    initial REG_REQ = '0;
    // one strobe cycle; idle bus shows inverted junk, never the last value
    task automatic cyc(logic [11:0] a, logic w, logic [7:0] d);
        @(posedge REF_CLK);
        #1 REG_REQ = '{a, w, !w, d};
        @(posedge REF_CLK);
        #1 REG_REQ = '{~a, 1'b0, 1'b0, ~d};
    endtask
endmodule
`default_nettype wire

// ===== testbench/lechs_top_monitor.sv
// port checker for the lane error bank
// assumes it is bound onto lechs_top; lane 6 counters stand for all lanes, lane 7 for the counter clear
`timescale 1ns/1ps
`default_nettype none
module lechs_top_monitor
(
    input wire logic                        REF_CLK,
    input wire logic                        NRST,
    input wire lechs_pkg::lechs_req_t       REG_REQ,
    input wire logic [7:0]                  REG_RDATA,
    input wire logic                        REG_RVALID,
    input wire logic [3:0]                  LANE_SOFT_RESET,
    input wire lechs_pkg::lechs_err_t [3:0] LANE_ERR,
    input wire logic [3:0]                  LANE_CNT_CLR,
    input wire logic [3:0][2:0][7:0]        LANE_COUNT,
    input wire logic [2:0]                  LANE6_HOLD_EN,
    input wire logic [2:0]                  LANE7_HOLD_EN,
    input wire logic [2:0]                  LANE6_REACHED,
    input wire logic [2:0]                  LANE7_REACHED
);
    import lechs_pkg::*;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    // counter, hold reset, status and clear behaviour
    a_hold_at_ff: assert property (
        LANE6_HOLD_EN[1] && LANE_COUNT[2][1] == 8'hFF && !LANE_CNT_CLR[2] |=> LANE_COUNT[2][1] == 8'hFF)
        else $error("held count left 0xFF");
    a_wrap_to_zero: assert property (
        !LANE6_HOLD_EN[2] && LANE_COUNT[2][2] == 8'hFF && LANE_ERR[2][2] && !LANE_CNT_CLR[2]
        |=> LANE_COUNT[2][2] == 8'h00) else $error("free count did not wrap");
    a_bit_map: assert property (
        LANE_ERR[2][0] && !LANE_CNT_CLR[2] && LANE_COUNT[2][0] != 8'hFF
        |=> LANE_COUNT[2][0] == $past(LANE_COUNT[2][0]) + 8'h01) else $error("bit 0 event missed");
    a_hold_reset: assert property (
        $rose(NRST) |-> LANE6_HOLD_EN == 3'h7 && LANE7_HOLD_EN == 3'h7) else $error("hold reset value");
    a_reached_set: assert property (
        LANE_COUNT[2][1] == 8'hFF |-> LANE6_REACHED[1]) else $error("reached flag missing");
    a_status_state: assert property (
        REG_RVALID && $past(REG_REQ.addr) == 12'h490
        |-> REG_RDATA[7:3] == {4'h0, !$past(LANE_SOFT_RESET[0], 2)}) else $error("status bit 3 wrong");
    a_clear_reached: assert property (
        LANE_CNT_CLR[3] |=> LANE7_REACHED == 3'h0 ##1 LANE_COUNT[3] != 24'hFFFFFF) else $error("clear kept flag");
    // main scenarios reached
    c_wrap: cover property (LANE_COUNT[2][2] == 8'hFF ##1 LANE_COUNT[2][2] == 8'h00);
    c_hold: cover property (LANE_COUNT[2][1] == 8'hFF ##1 LANE_COUNT[2][1] == 8'hFF);
    c_stat: cover property (REG_RVALID && REG_RDATA[3]);
endmodule
`default_nettype wire

// ===== testbench/lechs_top_tb.sv
// self-checking bench for lechs_top
// reads are noted in a queue and compared when read data comes back
`timescale 1ns/1ps
`default_nettype none
module lechs_top_tb;
    import lechs_pkg::*;
    logic                 clk, nrst, rvalid;
    lechs_req_t           req;
    logic [7:0]           rdata, v;
    logic [2:0]           h0, h1, h6, h7, r6, r7;
    logic [3:0]           srst, clr;
    lechs_err_t [3:0]     err;
    logic [3:0][2:0][7:0] cnt;
    logic [7:0]           exp_q[$];
    int                   bad_count, tests_run;
    logic [31:0]          seed = 32'h144DE;
    lechs_top lechs_top_inst (.REF_CLK(clk), .NRST(nrst), .REG_REQ(req), .REG_RDATA(rdata),
        .REG_RVALID(rvalid), .LANE0_HOLD_EN(h0), .LANE1_HOLD_EN(h1), .LANE_SOFT_RESET(srst),
        .LANE_ERR(err), .LANE_CNT_CLR(clr), .LANE_COUNT(cnt), .LANE6_HOLD_EN(h6),
        .LANE7_HOLD_EN(h7), .LANE6_REACHED(r6), .LANE7_REACHED(r7));
    lechs_host lechs_host_inst (.REF_CLK(clk), .REG_REQ(req));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // note the expectation before the host issues the read
    task automatic rd(logic [11:0] a, logic [7:0] e);
        exp_q.push_back(e);
        lechs_host_inst.cyc(a, 1'b0, 8'h00);
    endtask
    // back to back error pulses, one per cycle
    task automatic pulse(lechs_err_t [3:0] e, int n);
        repeat (n)
        begin
            @(posedge clk);
            #1 err = e;
        end
        @(posedge clk);
        #1 err = '0;
    endtask
    task automatic finish_test();
        if (exp_q.size() != 0)
        begin
            bad_count++;
            $display("wrong value at %0t: %0d reads never answered", $time, exp_q.size());
        end
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // clock, read-back watcher and hang guard
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(negedge clk)
        if (rvalid === 1'b1)
            chk(rdata, exp_q.pop_front());
    initial
    begin
        #20000 bad_count++;
        finish_test();
    end
    // main sequence
    initial
    begin
        nrst = 1'b0;
        srst = 4'hF;
        clr = 4'h0;
        err = '0;
        h0 = 3'h4;
        h1 = 3'h7;
        repeat (16) @(posedge clk);
        #1 nrst = 1'b1;
        rd(12'h48E, 8'h07);
        rd(12'h48F, 8'h07);
        rd(12'h490, 8'h00);
        rd(12'h492, 8'h00);
        $display("test reset values done");
        v = 8'(xs());
        lechs_host_inst.cyc(12'h48E, 1'b1, 8'hFA);
        lechs_host_inst.cyc(12'h48F, 1'b1, v);
        rd(12'h48E, 8'h02);
        rd(12'h48F, {5'h0, v[2:0]});
        chk({5'h0, h6}, 8'h02);
        chk({5'h0, h7}, {5'h0, v[2:0]});
        srst = 4'hA;
        rd(12'h490, 8'h08);
        rd(12'h491, 8'h00);
        $display("test hold write done");
        pulse(12'hFD1, 255);
        chk(cnt[2][1], 8'hFF);
        chk({5'h0, r6}, 8'h07);
        chk({5'h0, r7}, 8'h07);
        rd(12'h490, 8'h09);
        rd(12'h491, 8'h02);
        pulse(12'hFD1, 1);
        chk(cnt[2][2], 8'h00);
        chk(cnt[2][1], 8'hFF);
        chk(cnt[2][0], 8'h00);
        chk(cnt[0][0], 8'h00);
        chk(cnt[1][1], 8'hFF);
        chk(cnt[3][2], {8{v[2]}});
        chk(cnt[3][1], {8{v[1]}});
        chk(cnt[3][0], {8{v[0]}});
        chk({5'h0, r7}, 8'h07);
        chk({5'h0, r6}, 8'h07);
        $display("test terminal count done");
        @(posedge clk);
        #1 clr = 4'hC;
        @(posedge clk);
        #1 clr = 4'h0;
        chk(cnt[2][1], 8'h00);
        chk({5'h0, r6}, 8'h00);
        chk({5'h0, r7}, 8'h00);
        chk(cnt[3][0], 8'h00);
        rd(12'h490, 8'h09);
        repeat (3) @(posedge clk);
        $display("test counter clear done");
        finish_test();
    end
endmodule
bind lechs_top lechs_top_monitor lechs_top_monitor_inst (.REF_CLK, .NRST, .REG_REQ, .REG_RDATA, .REG_RVALID,
    .LANE_SOFT_RESET, .LANE_ERR, .LANE_CNT_CLR, .LANE_COUNT, .LANE6_HOLD_EN, .LANE7_HOLD_EN,
    .LANE6_REACHED, .LANE7_REACHED);
`default_nettype wire
